/* File: hw/ref3_cfg_map.svh */
// register map constants for the third reference input configuration block
// assumes inclusion by the design module and the testbench only
`ifndef REF3_CFG_MAP_SVH
`define REF3_CFG_MAP_SVH
// printed offset is not a multiple of four: index, byte address is 4x
`define INPUT3_REFERENCE_CONFIG_IDX 8'h22
`define INPUT3_REFERENCE_CONFIG_ADDR 10'h088
`define INPUT3_REFERENCE_CONFIG_RST 8'h00
// field positions
`define PROG_DIV_BIT 7
`define FIX8K_BIT 6
`define PROFILE_HI 5
`define PROFILE_LO 4
`define FREQ_HI 3
`define FREQ_LO 0
// frequency codes
`define FREQ_8K 4'h0
`define FREQ_T1E1 4'h1
`define FREQ_6M48 4'h2
`define FREQ_19M44 4'h3
`define FREQ_25M92 4'h4
`define FREQ_38M88 4'h5
`define FREQ_51M84 4'h6
`define FREQ_77M76 4'h7
`define FREQ_155M52 4'h8
`define FREQ_2K 4'h9
`define FREQ_4K 4'hA
`define FREQ_LAST_USED 4'hA
// unmapped reads return this
`define UNMAPPED_READ 32'h0000_0000
`endif

/* File: hw/ref3_cfg_pkg.sv */
// types shared by the third reference input configuration block
// assumes the map header sits beside it
package ref3_cfg_pkg;
  // routing selection seen by the DPLL; the frequency monitor gets monitor_divided instead
  typedef enum logic [2:0] {
    ROUTE_DIRECT = 3'b001,
    ROUTE_PROG = 3'b010,
    ROUTE_FIX8K = 3'b100
  } route_t;
  // nominal frequency class, one-hot; 4k has a slot of its own
  typedef enum logic [12:0] {
    F_8K = 13'h0001, F_1544K = 13'h0002, F_2048K = 13'h0004, F_6M48 = 13'h0008,
    F_19M44 = 13'h0010, F_25M92 = 13'h0020, F_38M88 = 13'h0040, F_51M84 = 13'h0080,
    F_77M76 = 13'h0100, F_155M52 = 13'h0200, F_2K = 13'h0400, F_4K = 13'h0800,
    F_UNUSED = 13'h1000
  } freq_t;
  // configuration carried to the datapath
  typedef struct packed {
    logic prog_div;
    logic fix8k;
    logic [1:0] profile;
    logic [3:0] freq_code;
  } cfg_t;
  // decoded controls carried to the monitor and DPLL
  typedef struct packed {
    route_t dpll_route;
    logic monitor_divided;
    logic [1:0] profile;
    freq_t nominal;
    logic freq_valid;
  } ctl_t;
endpackage : ref3_cfg_pkg

/* File: hw/ref3_cfg.sv */
// third reference input configuration register with its routing logic
// assumes classic wishbone master, 100 MHz SYS_CLK, ratio from elsewhere
// Function
// - bit 7 routes input through programmable divider
// - bit 6 routes input through fixed 8k divider, DPLL path only
// - programmable divider select overrides fixed select
// - bits 5:4 pick one of four bucket profiles
// - bits 3:0 declare the nominal input frequency
// - code 0 8k, code 1 1544/2048k by mode
// - codes 2..5 are 6.48 to 38.88 MHz
// - codes 6..8 are 51.84 to 155.52 MHz
// - codes 9,10 are 2k,4k; rest unused
// - own bucket per channel, shared four profiles
`include "ref3_cfg_map.svh"
module ref3_cfg
  import ref3_cfg_pkg::*;
#(
  parameter int DIV_W = 14 // programmable ratio width
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [9:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // reference input and divider sources
  input wire logic THIRD_REFERENCE_INPUT,
  input wire logic FIX8K_TICK,
  input wire logic [DIV_W-1:0] PROG_DIV_RATIO,
  input wire logic SONET_SDH_RATE_SELECT,
  // decoded controls and routed clocks
  output ctl_t CTL,
  output logic DPLL_INPUT,
  output logic MONITOR_INPUT,
  output logic INPUT3_FIXED_8K_DIVIDE_SELECT,
  output logic [1:0] INPUT3_ACTIVITY_PROFILE_SELECT
);
  ////////////////////////////////////////////////////////////////////////
  // bus decode
  cfg_t cfg_r; // the register
  logic ack_r; // one-cycle acknowledge
  logic [31:0] rdat_r; // registered read data
  wire req = WB_CYC_I && WB_STB_I && !ack_r; // new request
  wire hit = (WB_ADR_I == `INPUT3_REFERENCE_CONFIG_ADDR);
  wire wr_low = req && WB_WE_I && hit && WB_SEL_I[0];
  wire [31:0] rd_val = hit ? {24'h00_0000, cfg_r} : `UNMAPPED_READ;

  // register write; only the low byte lane holds data
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      cfg_r <= cfg_t'(`INPUT3_REFERENCE_CONFIG_RST);
    end else if (wr_low) begin
      cfg_r <= cfg_t'(WB_DAT_I[7:0]);
    end
  end

  // acknowledge every request the cycle after, mapped or not
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      rdat_r <= req ? rd_val : 32'h0000_0000;
    end
  end
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;

  ////////////////////////////////////////////////////////////////////////
  // routing decode
  wire prog_sel = cfg_r.prog_div;
  wire fix_sel = cfg_r.fix8k && !prog_sel;
  route_t route_w;
  assign route_w = prog_sel ? ROUTE_PROG : (fix_sel ? ROUTE_FIX8K : ROUTE_DIRECT);

  // nominal frequency decode; mode bit splits code one
  freq_t nom_w;
  // unused codes also drop freq_valid below
  always_comb begin
    case (cfg_r.freq_code)
      `FREQ_8K: nom_w = F_8K;
      `FREQ_T1E1: nom_w = SONET_SDH_RATE_SELECT ? F_1544K : F_2048K;
      `FREQ_6M48: nom_w = F_6M48;
      `FREQ_19M44: nom_w = F_19M44;
      `FREQ_25M92: nom_w = F_25M92;
      `FREQ_38M88: nom_w = F_38M88;
      `FREQ_51M84: nom_w = F_51M84;
      `FREQ_77M76: nom_w = F_77M76;
      `FREQ_155M52: nom_w = F_155M52;
      `FREQ_2K: nom_w = F_2K;
      `FREQ_4K: nom_w = F_4K;
      default: nom_w = F_UNUSED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // programmable divider: toggles every ratio input edges
  logic in_d_r; // previous input level
  logic [DIV_W-1:0] cnt_r; // edge counter
  logic pdiv_r; // divided clock
  wire rise = THIRD_REFERENCE_INPUT && !in_d_r;
  // ratio 0 acts as ratio 1, so a cleared ratio register cannot stall the path
  wire last = (PROG_DIV_RATIO <= DIV_W'(1)) || (cnt_r >= PROG_DIV_RATIO - DIV_W'(1));

  // counts only this channel's edges; no other channel is touched
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN || !prog_sel) begin
      in_d_r <= THIRD_REFERENCE_INPUT; // tracks the pin: no false edge on enable
      cnt_r <= '0;
      pdiv_r <= 1'b0;
    end else begin
      in_d_r <= THIRD_REFERENCE_INPUT;
      if (rise) begin
        cnt_r <= last ? '0 : cnt_r + DIV_W'(1);
        if (last) begin
          pdiv_r <= !pdiv_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; DPLL, monitor and CTL registered, the two selects decoded from cfg_r
  logic dpll_r, mon_r;
  ctl_t ctl_r;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      dpll_r <= 1'b0;
      mon_r <= 1'b0;
      ctl_r <= '{ROUTE_DIRECT, 1'b0, 2'b00, F_8K, 1'b1};
    end else begin
      dpll_r <= prog_sel ? pdiv_r : (fix_sel ? FIX8K_TICK : THIRD_REFERENCE_INPUT);
      mon_r <= prog_sel ? pdiv_r : THIRD_REFERENCE_INPUT;
      ctl_r <= '{route_w, prog_sel, cfg_r.profile, nom_w,
                 cfg_r.freq_code <= `FREQ_LAST_USED};
    end
  end
  assign DPLL_INPUT = dpll_r;
  assign MONITOR_INPUT = mon_r;
  assign CTL = ctl_r;
  assign INPUT3_FIXED_8K_DIVIDE_SELECT = fix_sel;
  assign INPUT3_ACTIVITY_PROFILE_SELECT = cfg_r.profile;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_prog_priority;
    @(posedge SYS_CLK) disable iff (!RSTN) prog_sel |-> ##1 ctl_r.dpll_route == ROUTE_PROG;
  endproperty
  a_prog_priority: assert property (p_prog_priority) else $error("prog route lost");
  property p_fix_route;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (cfg_r.fix8k && !cfg_r.prog_div) |=> ctl_r.dpll_route == ROUTE_FIX8K;
  endproperty
  a_fix_route: assert property (p_fix_route) else $error("fixed route wrong");
  property p_direct;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (!cfg_r.fix8k && !cfg_r.prog_div) |=> dpll_r == $past(THIRD_REFERENCE_INPUT);
  endproperty
  a_direct: assert property (p_direct) else $error("direct path wrong");
  property p_mon_div;
    @(posedge SYS_CLK) disable iff (!RSTN) prog_sel |=> mon_r == $past(pdiv_r);
  endproperty
  a_mon_div: assert property (p_mon_div) else $error("monitor not divided");
  property p_write;
    @(posedge SYS_CLK) disable iff (!RSTN) wr_low |=> cfg_r == $past(WB_DAT_I[7:0]);
  endproperty
  a_write: assert property (p_write) else $error("write lost");
  property p_profile;
    @(posedge SYS_CLK) disable iff (!RSTN) 1'b1 |=> ctl_r.profile == $past(cfg_r.profile);
  endproperty
  a_profile: assert property (p_profile) else $error("profile mismatch");
  property p_code1;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (cfg_r.freq_code == `FREQ_T1E1 && SONET_SDH_RATE_SELECT) |=> ctl_r.nominal == F_1544K;
  endproperty
  a_code1: assert property (p_code1) else $error("code one wrong");
  property p_155;
    @(posedge SYS_CLK) disable iff (!RSTN)
      cfg_r.freq_code == `FREQ_155M52 |=> ctl_r.nominal == F_155M52;
  endproperty
  a_155: assert property (p_155) else $error("code eight wrong");
  property p_6m48;
    @(posedge SYS_CLK) disable iff (!RSTN)
      cfg_r.freq_code == `FREQ_6M48 |=> ctl_r.nominal == F_6M48;
  endproperty
  a_6m48: assert property (p_6m48) else $error("code two wrong");
  property p_unused;
    @(posedge SYS_CLK) disable iff (!RSTN) cfg_r.freq_code > `FREQ_LAST_USED |=> !ctl_r.freq_valid;
  endproperty
  a_unused: assert property (p_unused) else $error("unused code valid");
  property p_reset;
    @(posedge SYS_CLK) !RSTN |=> cfg_r == cfg_t'(8'h00) && !ack_r;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");
  // one-cycle pulse; a request held on gets a new ack every second cycle
  property p_ack;
    @(posedge SYS_CLK) disable iff (!RSTN) req |=> ack_r ##1 !ack_r;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_4k;
    @(posedge SYS_CLK) disable iff (!RSTN)
      cfg_r.freq_code == `FREQ_4K |=> ctl_r.nominal == F_4K;
  endproperty
  a_4k: assert property (p_4k) else $error("code ten wrong");
  property p_mon_direct;
    @(posedge SYS_CLK) disable iff (!RSTN)
      !prog_sel |=> mon_r == $past(THIRD_REFERENCE_INPUT);
  endproperty
  a_mon_direct: assert property (p_mon_direct) else $error("monitor not direct");
  // covers for the main scenarios
  c_prog: cover property (@(posedge SYS_CLK) disable iff (!RSTN) prog_sel && cfg_r.fix8k);
  c_fix: cover property (@(posedge SYS_CLK) disable iff (!RSTN) fix_sel);
  c_read: cover property (@(posedge SYS_CLK) disable iff (!RSTN) req && !WB_WE_I && hit);
  c_div: cover property (@(posedge SYS_CLK) disable iff (!RSTN) prog_sel && rise && last);
endmodule : ref3_cfg

/* File: testbench/ref3_src.sv */
// reference clock source model driving the third input and the 8k tick
// assumes a free-running sys clock; both lines run free, never parked
module ref3_src #(
  parameter int HALF = 4, // reference half period in sys clocks
  parameter int TICK_HALF = 20 // fixed divider output half period
) (
  // sampling clock
  input wire logic clk,
  // generated lines
  output logic ref_o,
  output logic tick_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int c_r = 0; // reference phase count
  int t_r = 0; // tick phase count
  initial begin
    ref_o = 1'b0;
    tick_o = 1'b0;
  end
  // toggles after the edge; a real source never stops between uses
  always @(posedge clk) begin
    c_r <= (c_r == HALF - 1) ? 0 : c_r + 1;
    t_r <= (t_r == TICK_HALF - 1) ? 0 : t_r + 1;
    if (c_r == HALF - 1) ref_o <= ~ref_o;
    if (t_r == TICK_HALF - 1) tick_o <= ~tick_o;
  end
endmodule : ref3_src

/* File: testbench/test_ref3_cfg.sv */
// self-checking bench for the third reference input configuration block
// assumes the design package, map header and the source model are compiled first
`include "ref3_cfg_map.svh"
module test_ref3_cfg import ref3_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////
  logic sys_clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
  logic ack, ref_in, tick, sonet = 1'b1, dpll, mon, fix_sel;
  logic [13:0] ratio = 14'h0002;
  logic [1:0] prof_sel;
  ctl_t ctl;
  int n_mismatch = 0, total_checks = 0, nd, nm;
  freq_t ftab [0:15] = '{F_8K, F_1544K, F_6M48, F_19M44, F_25M92, F_38M88, F_51M84,
    F_77M76, F_155M52, F_2K, F_4K, F_UNUSED, F_UNUSED, F_UNUSED, F_UNUSED, F_UNUSED};
  localparam logic [9:0] RA = `INPUT3_REFERENCE_CONFIG_ADDR; // register byte address
  always #5 sys_clk = ~sys_clk; // 100 MHz
  ref3_src SRC (.clk(sys_clk), .ref_o(ref_in), .tick_o(tick));
  ref3_cfg DUT (.SYS_CLK(sys_clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .THIRD_REFERENCE_INPUT(ref_in), .FIX8K_TICK(tick), .PROG_DIV_RATIO(ratio),
    .SONET_SDH_RATE_SELECT(sonet), .CTL(ctl), .DPLL_INPUT(dpll), .MONITOR_INPUT(mon),
    .INPUT3_FIXED_8K_DIVIDE_SELECT(fix_sel), .INPUT3_ACTIVITY_PROFILE_SELECT(prof_sel));
  ////////////////////////////////////////////////////////////////
  // verdict and stop, also reached from a timeout
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // single compare point
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // classic cycle; request held until ack, then two idle cycles
  task automatic wb(input logic w, input logic [9:0] a, input logic [3:0] s,
      input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    if (ack !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk); // lets the decoded controls land
  endtask : wb
  // rising edges of both routed clocks over 400 cycles
  task automatic edges(input int ed, input int em);
    logic pd, pm;
    nd = 0; nm = 0; pd = dpll; pm = mon;
    repeat (400) begin
      @(posedge sys_clk);
      if (dpll === 1'b1 && pd === 1'b0) nd++;
      if (mon === 1'b1 && pm === 1'b0) nm++;
      pd = dpll; pm = mon;
    end
    chk("dpll edges near", 32'(nd >= ed - 1 && nd <= ed + 1), 32'h0000_0001);
    chk("monitor edges near", 32'(nm >= em - 1 && nm <= em + 1), 32'h0000_0001);
  endtask : edges
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wb(1'b0, RA, 4'hF, 32'h0000_0000);
    chk("reg", q, 32'h0000_0000);
    chk("route", 32'(ctl.dpll_route), 32'(ROUTE_DIRECT));
    chk("nominal", 32'(ctl.nominal), 32'(F_8K));
    chk("profile", 32'(prof_sel), 32'h0000_0000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_freq();
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, RA, 4'h1, 32'(i) | 32'(i % 4) << 4);
      chk("nominal", 32'(ctl.nominal), 32'(ftab[i]));
      chk("valid", 32'(ctl.freq_valid), 32'(i <= 10));
      chk("profile", 32'(prof_sel), 32'(i % 4));
      chk("ctl profile", 32'(ctl.profile), 32'(i % 4));
    end
    sonet <= 1'b0;
    wb(1'b1, RA, 4'h1, 32'h0000_0001);
    chk("nominal 2048", 32'(ctl.nominal), 32'(F_2048K));
    $display("t_freq done");
  endtask : t_freq
  task automatic t_route();
    wb(1'b1, RA, 4'h1, 32'h0000_0000);
    edges(50, 50);
    wb(1'b1, RA, 4'h1, 32'h0000_0040);
    chk("fixed sel", 32'(fix_sel), 32'h0000_0001);
    chk("route", 32'(ctl.dpll_route), 32'(ROUTE_FIX8K));
    chk("mon undivided", 32'(ctl.monitor_divided), 32'h0000_0000);
    edges(10, 50);
    wb(1'b1, RA, 4'h1, 32'h0000_00C0);
    wb(1'b0, RA, 4'hF, 32'h0000_0000);
    chk("reg", q, 32'h0000_00C0);
    chk("fixed sel", 32'(fix_sel), 32'h0000_0000);
    chk("route", 32'(ctl.dpll_route), 32'(ROUTE_PROG));
    chk("mon div", 32'(ctl.monitor_divided), 32'h0000_0001);
    edges(12, 12);
    ratio <= 14'h0000;
    wb(1'b1, RA, 4'h1, 32'h0000_0080);
    edges(25, 25);
    $display("t_route done");
  endtask : t_route
  task automatic t_bus();
    wb(1'b1, RA, 4'h1, 32'hFFFF_FF25);
    wb(1'b1, RA + 10'h004, 4'hF, 32'h0000_00FF);
    wb(1'b0, RA + 10'h004, 4'hF, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    wb(1'b1, RA, 4'h2, 32'h0000_0013);
    wb(1'b0, RA, 4'hF, 32'h0000_0000);
    chk("reg", q, 32'h0000_0025);
    $display("t_bus done");
  endtask : t_bus
  // reset again in mid-run with a non-zero register
  task automatic t_rerun();
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, RA, 4'hF, 32'h0000_0000);
    chk("reg after reset", q, 32'h0000_0000);
    chk("nominal after reset", 32'(ctl.nominal), 32'(F_8K));
    chk("profile after reset", 32'(prof_sel), 32'h0000_0000);
    $display("t_rerun done");
  endtask : t_rerun
  ////////////////////////////////////////////////////////////////
  // main sequence with the 4-cycle reset
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_freq();
    t_route();
    t_bus();
    t_rerun();
    end_of_test();
  end
endmodule : test_ref3_cfg
